// file: acje_map.svh
`ifndef ACJE_MAP_SVH
`define ACJE_MAP_SVH
// Overview of operation
// - Add-with-carry sums accumulator, source, carry into accumulator
// - Carry from bit 7, aux from bit 3
// - Wrap flag is carry6 xor carry7
// - Add-with-carry takes register, direct, indirect, immediate sources
// - Compat map needs escape for extended forms
// - Native map needs escape for legacy forms with low nibble 6 to F
// - Second byte nibble selects word/dword indirect
// - Port direct operand adds one state
// - AND accumulator into port adds two states
// - Page jump keeps upper bits of advanced pointer
// - AND stores into accumulator, destination byte or port latch
// - AND allows twelve operand combinations
// - AND on port reads output latch
// - Bit AND clears carry on zero
// - Complemented bit source, direct bit only

// Register byte offsets
`define ACJE_OFS_CTRL 8'h00
`define ACJE_OFS_INSN 8'h04
`define ACJE_OFS_SRC  8'h08
`define ACJE_OFS_ACC  8'h0C
`define ACJE_OFS_PSW  8'h10
`define ACJE_OFS_IP   8'h14
`define ACJE_OFS_STAT 8'h18
`define ACJE_OFS_PORT 8'h1C
`define ACJE_LAST_IDX 6'h07

// Control bits
`define ACJE_CTRL_GO     0
`define ACJE_CTRL_NATIVE 1
`define ACJE_CTRL_PORT   2

// Opcode fields
`define ACJE_ESC    8'hA5
`define ACJE_BESC   8'hA9
`define ACJE_HI_ADD 4'h2
`define ACJE_HI_ADC 4'h3
`define ACJE_HI_AND 4'h5
`define ACJE_AND_DA 8'h52
`define ACJE_AND_DI 8'h53
`define ACJE_BAND   8'h82
`define ACJE_BNAND  8'hB0
`define ACJE_JMP    5'h01
`define ACJE_E_IMM  4'h0
`define ACJE_E_DIR  4'h1
`define ACJE_E_D16  4'h3
`define ACJE_E_IW   4'h9
`define ACJE_E_ID   4'hB
`define ACJE_B_POS  4'h8
`define ACJE_B_NEG  4'hF
`define ACJE_IP_STEP 16'h0002

// Reset values
`define ACJE_ACC_RST  8'h00
`define ACJE_PSW_RST  5'h00
`define ACJE_IP_RST   16'h0000
`define ACJE_PORT_RST 8'hFF
`endif

// file: acje_pkg.sv
`default_nettype none
package acje_pkg;
    typedef enum logic [1:0] {
        acje_idle   = 2'b00,
        acje_exec   = 2'b01,
        acje_commit = 2'b11
    } acje_state_t;
    typedef enum logic [2:0] {
        k_reg, k_dir, k_ind, k_imm, k_iw, k_id, k_bit, k_acc
    } acje_src_t;
    typedef enum logic [2:0] {
        c_bad, c_add, c_add_with_carry_op, c_and, c_bool, c_jmp
    } acje_cls_t;
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } acje_apb_req_t;
    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } acje_apb_rsp_t;
endpackage
`default_nettype wire

// file: acje_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "acje_map.svh"
module acje_exec (
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire acje_pkg::acje_apb_req_t apb_req,
    output var  acje_pkg::acje_apb_rsp_t apb_rsp,
    input  wire logic [7:0]              port_pin,
    output logic [7:0]                   port_out
);
    import acje_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    acje_state_t   st_q;
    acje_apb_rsp_t rsp_q;
    logic        native_q, port_q, bad_q;
    logic [31:0] insn_q;
    logic [8:0]  src_q;
    logic [7:0]  acc_q, dst_q, latch_q, pin1_q, pin2_q;
    logic [4:0]  psw_q;
    logic [15:0] ip_q;
    logic [1:0]  cnt_q, xtra_q;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire       pfx  = insn_q[7:0] == `ACJE_ESC;
    wire [7:0] op   = pfx ? insn_q[15:8] : insn_q[7:0];
    wire [7:0] o1   = pfx ? insn_q[23:16] : insn_q[15:8];
    wire [7:0] o2   = pfx ? insn_q[31:24] : insn_q[23:16];
    wire [3:0] hi   = op[7:4];
    wire [3:0] lo   = op[3:0];
    wire [3:0] en   = o1[3:0];
    // Mode bits as a launch in the same control write sees them
    wire       ctrl_wr = apb_req.psel && apb_req.penable && rsp_q.pready && apb_req.pwrite
                         && st_q == acje_idle && apb_req.paddr == `ACJE_OFS_CTRL;
    wire       nat_v   = ctrl_wr ? apb_req.pwdata[`ACJE_CTRL_NATIVE] : native_q;
    wire       prt_v   = ctrl_wr ? apb_req.pwdata[`ACJE_CTRL_PORT] : port_q;
    wire       same = pfx == nat_v;
    wire       alu_hi = hi == `ACJE_HI_ADD || hi == `ACJE_HI_ADC || hi == `ACJE_HI_AND;
    wire       lo_leg = lo >= 4'h6 && lo <= 4'hB;
    wire       lo_hi  = lo >= 4'hC;
    wire       leg_ok = (lo_leg || lo_hi) && same;
    wire       ext    = lo_hi && !same && hi != `ACJE_HI_ADC;
    wire       e_ok   = en == `ACJE_E_IMM || en == `ACJE_E_DIR || en == `ACJE_E_D16
                        || en == `ACJE_E_IW || en == `ACJE_E_ID;
    wire       e_byte = ext && (lo == 4'hC || (lo == 4'hE && e_ok));
    wire       sl_ok  = (lo == 4'h4 || lo == 4'h5) && !pfx;
    wire       and_da = !pfx && op == `ACJE_AND_DA;
    wire       and_dir = and_da || (!pfx && op == `ACJE_AND_DI);
    wire       is_jmp = !pfx && op[4:0] == `ACJE_JMP;
    wire       bx     = op == `ACJE_BESC && !same && !o1[3]
                        && (o1[7:4] == `ACJE_B_POS || o1[7:4] == `ACJE_B_NEG);
    wire       b_neg  = (!pfx && op == `ACJE_BNAND) || (bx && o1[7:4] == `ACJE_B_NEG);
    wire       is_bool = (!pfx && op == `ACJE_BAND) || b_neg || bx;
    wire       alu_ok = alu_hi && (sl_ok || leg_ok || e_byte);

    // Instruction class
    acje_cls_t cls;
    assign cls = and_dir ? c_and :
                 is_jmp ? c_jmp :
                 is_bool ? c_bool :
                 !alu_ok ? c_bad :
                 hi == `ACJE_HI_ADD ? c_add :
                 hi == `ACJE_HI_ADC ? c_add_with_carry_op : c_and;

    // Source operand kind
    acje_src_t srck;
    assign srck = is_bool ? k_bit :
                  and_da ? k_acc :
                  (lo == 4'h4 || and_dir) ? k_imm :
                  lo == 4'h5 ? k_dir :
                  !ext ? (lo_leg && lo < 4'h8 ? k_ind : k_reg) :
                  lo == 4'hC ? k_reg :
                  en == `ACJE_E_IMM ? k_imm :
                  en == `ACJE_E_IW ? k_iw :
                  en == `ACJE_E_ID ? k_id : k_dir;

    // Destination and state timing
    wire       dest_port = and_dir && port_q;
    wire       dest_dst  = (and_dir && !port_q) || ext;
    wire       dir_use   = srck == k_dir || and_dir || is_bool;
    wire [1:0] extra     = !(prt_v && dir_use) ? 2'd0 :
                           and_da ? 2'd2 : 2'd1;

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    wire [7:0] imm_v = lo == 4'h4 ? o1 : o2;
    wire [7:0] sv = srck == k_imm ? imm_v :
                    srck == k_acc ? acc_q :
                    (srck == k_dir && port_q) ? pin2_q : src_q[7:0];
    wire [7:0] dv = dest_port ? latch_q :
                    dest_dst ? dst_q : acc_q;
    wire       add_c = cls == c_add || cls == c_add_with_carry_op;
    wire       cin   = cls == c_add_with_carry_op && psw_q[0];
    wire [4:0] s_lo  = {1'b0, dv[3:0]} + {1'b0, sv[3:0]} + {4'h0, cin};
    wire [7:0] s_67  = {1'b0, dv[6:0]} + {1'b0, sv[6:0]} + {7'h00, cin};
    wire [8:0] s9    = {1'b0, dv} + {1'b0, sv} + {8'h00, cin};
    wire [7:0] res   = cls == c_and ? (dv & sv) : s9[7:0];
    wire       bitv  = b_neg ? !src_q[8] : src_q[8];
    wire [15:0] ip_nx = ip_q + `ACJE_IP_STEP;
    wire [15:0] jmp_t = {ip_nx[15:11], op[7:5], o1};

    // Flag results per class
    wire [4:0] psw_x = add_c ? {res == 8'h00, res[7], s_67[7] ^ s9[8], s_lo[4], s9[8]} :
                       cls == c_and ? {res == 8'h00, res[7], psw_q[2:0]} :
                       {psw_q[4:1], psw_q[0] & bitv};
    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire       idle   = st_q == acje_idle;
    wire       setup  = apb_req.psel && !apb_req.penable;
    wire       xfer   = apb_req.psel && apb_req.penable && rsp_q.pready;
    wire       wr_ok  = xfer && apb_req.pwrite && idle;
    wire [7:0] a      = apb_req.paddr;
    wire       mapped = a[1:0] == 2'b00 && a[7:2] <= `ACJE_LAST_IDX;
    wire       go     = wr_ok && a == `ACJE_OFS_CTRL && apb_req.pwdata[`ACJE_CTRL_GO];
    wire       commit = st_q == acje_commit;
    wire       wr_acc = (add_c || cls == c_and) && !dest_dst && !dest_port;
    wire [31:0] stat  = {22'h000000, srck, cls, xtra_q, bad_q, !idle};
    wire [31:0] rd_v  = a == `ACJE_OFS_CTRL ? {29'h0, port_q, native_q, 1'b0} :
                        a == `ACJE_OFS_INSN ? insn_q :
                        a == `ACJE_OFS_SRC ? {23'h0, src_q} :
                        a == `ACJE_OFS_ACC ? {16'h0, dst_q, acc_q} :
                        a == `ACJE_OFS_PSW ? {27'h0, psw_q} :
                        a == `ACJE_OFS_IP ? {16'h0, ip_q} :
                        a == `ACJE_OFS_STAT ? stat :
                        a == `ACJE_OFS_PORT ? {16'h0, pin2_q, latch_q} : 32'h0;

    // APB answer, zero wait states
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rsp_q <= '0;
        end else begin
            rsp_q.pready  <= setup;
            rsp_q.pslverr <= setup && (!mapped || (apb_req.pwrite && !idle));
            rsp_q.prdata  <= setup ? rd_v : 32'h0;
        end
    end

    // Pin synchroniser
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pin1_q <= 8'h00;
            pin2_q <= 8'h00;
        end else begin
            pin1_q <= port_pin;
            pin2_q <= pin1_q;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q  <= acje_idle;
            cnt_q <= 2'd0;
        end else begin
            case (st_q)
                acje_idle: begin
                    if (go && cls != c_bad) begin
                        st_q  <= acje_exec;
                        cnt_q <= extra;
                    end
                end
                acje_exec: begin
                    if (cnt_q == 2'd0) begin
                        st_q <= acje_commit;
                    end else begin
                        cnt_q <= cnt_q - 2'd1;
                    end
                end
                acje_commit: st_q <= acje_idle;
                default: st_q <= acje_idle;
            endcase
        end
    end

    // Status of last launch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            bad_q  <= 1'b0;
            xtra_q <= 2'd0;
        end else if (go) begin
            bad_q  <= cls == c_bad;
            xtra_q <= extra;
        end
    end

    // Software-written setup registers
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            native_q <= 1'b0;
            port_q   <= 1'b0;
            insn_q   <= 32'h0;
            src_q    <= 9'h000;
        end else if (wr_ok) begin
            if (a == `ACJE_OFS_CTRL) begin
                native_q <= apb_req.pwdata[`ACJE_CTRL_NATIVE];
                port_q   <= apb_req.pwdata[`ACJE_CTRL_PORT];
            end
            if (a == `ACJE_OFS_INSN) begin
                insn_q <= apb_req.pwdata;
            end
            if (a == `ACJE_OFS_SRC) begin
                src_q <= apb_req.pwdata[8:0];
            end
        end
    end

    // Accumulator and destination byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_q <= `ACJE_ACC_RST;
            dst_q <= `ACJE_ACC_RST;
        end else if (wr_ok && a == `ACJE_OFS_ACC) begin
            acc_q <= apb_req.pwdata[7:0];
            dst_q <= apb_req.pwdata[15:8];
        end else if (commit && wr_acc) begin
            acc_q <= res;
        end else if (commit && (add_c || cls == c_and) && dest_dst) begin
            dst_q <= res;
        end
    end

    // Flags, instruction pointer, port latch
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            psw_q   <= `ACJE_PSW_RST;
            ip_q    <= `ACJE_IP_RST;
            latch_q <= `ACJE_PORT_RST;
        end else begin
            if (wr_ok && a == `ACJE_OFS_PSW) begin
                psw_q <= apb_req.pwdata[4:0];
            end else if (commit && cls != c_jmp) begin
                psw_q <= psw_x;
            end
            if (wr_ok && a == `ACJE_OFS_IP) begin
                ip_q <= apb_req.pwdata[15:0];
            end else if (commit && cls == c_jmp) begin
                ip_q <= jmp_t;
            end
            if (wr_ok && a == `ACJE_OFS_PORT) begin
                latch_q <= apb_req.pwdata[7:0];
            end else if (commit && dest_port) begin
                latch_q <= res;
            end
        end
    end

    assign apb_rsp  = rsp_q;
    assign port_out = latch_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    add_with_carry_op_result_a: assert property (
        commit && cls == c_add_with_carry_op && wr_acc
        |=> acc_q == 8'($past(dv) + $past(sv) + {7'h00, $past(psw_q[0])}))
        else $error("add with carry result wrong");
    carry_flags_a: assert property (
        commit && add_c |=> psw_q[0] == $past(s9[8]) && psw_q[1] == $past(s_lo[4]))
        else $error("carry flags wrong");
    wrap_flag_a: assert property (
        commit && add_c
        |=> psw_q[2] == ($past(dv[7]) == $past(sv[7]) && $past(s9[7]) != $past(dv[7])))
        else $error("wrap flag wrong");
    port_one_a: assert property (
        go && cls != c_bad && prt_v && dir_use && !and_da
        |=> (st_q == acje_exec)[*2] ##1 st_q == acje_commit)
        else $error("port access not one extra state");
    port_two_a: assert property (
        go && prt_v && and_da |=> (st_q == acje_exec)[*3] ##1 st_q == acje_commit)
        else $error("port write not two extra states");
    page_jump_a: assert property (
        commit && cls == c_jmp
        |=> ip_q == {$past(ip_nx[15:11]), $past(op[7:5]), $past(o1)})
        else $error("page jump target wrong");
    and_keep_a: assert property (
        commit && cls == c_and
        |=> psw_q[2:0] == $past(psw_q[2:0]) && psw_q[4] == ($past(res) == 8'h00))
        else $error("and flags wrong");
    bool_clear_a: assert property (
        commit && cls == c_bool |=> psw_q[0] == ($past(psw_q[0]) && $past(bitv)))
        else $error("bit and carry wrong");
    latch_src_a: assert property (
        commit && dest_port |=> port_out == ($past(latch_q) & $past(sv)))
        else $error("port and not from latch");
    map_reject_a: assert property (
        go && cls == c_bad |=> bad_q && st_q == acje_idle)
        else $error("bad opcode launched");

    add_with_carry_op_run_c: cover property (commit && cls == c_add_with_carry_op);
    jump_run_c: cover property (commit && cls == c_jmp);
    port_and_c: cover property (commit && dest_port && and_da);
    bad_op_c: cover property (go && cls == c_bad);
endmodule
`default_nettype wire

// file: acje_note_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: acje_port_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port pin stand-in for the board side
// ----------------------------------------
module acje_port_model (
    input  wire logic [7:0] level,
    output logic [7:0]      port_pin
);
    // Pins show the level the bench asks for, never the latch
    assign port_pin = level;
endmodule
`default_nettype wire

// file: add_carry_and_jump_exec_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "acje_map.svh"
`define ACJE_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module add_carry_and_jump_exec_tb_top;
    import acje_pkg::*;
    typedef struct packed {
        logic [31:0] insn;
        logic [1:0]  ctrl;
        logic [8:0]  src;
        logic [15:0] acc;
        logic [4:0]  psw;
        logic [15:0] e_acc;
        logic [4:0]  e_psw;
        logic [6:0]  e_stat;
    } acje_row_t;
    logic          ref_clk;
    logic          reset;
    acje_apb_req_t apb_req;
    acje_apb_rsp_t apb_rsp;
    logic [7:0]    pin_level;
    wire  [7:0]    port_pin;
    logic [7:0]    port_out;
    int            err_count;
    int            comparisons;
    logic [31:0]   rd;
    logic          er;
    acje_row_t     rows [16];
    acje_exec uut (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .apb_req  (apb_req),
        .apb_rsp  (apb_rsp),
        .port_pin (port_pin),
        .port_out (port_out)
    );
    acje_port_model pins (
        .level    (pin_level),
        .port_pin (port_pin)
    );
    // ----------------------------------------
    // Clock, watchdog and closing
    // ----------------------------------------
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        #500us;
        err_count++;
        end_sim();
    end
    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ----------------------------------------
    // Bus master and execution helpers
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge ref_clk);
        apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: addr, pwdata: wd};
        @(posedge ref_clk);
        apb_req.penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (apb_rsp.pready !== 1'h1);
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
    endtask
    task automatic go(input acje_row_t r);
        apb(1'h1, `ACJE_OFS_INSN, r.insn);
        apb(1'h1, `ACJE_OFS_SRC, {23'h0, r.src});
        apb(1'h1, `ACJE_OFS_ACC, {16'h0, r.acc});
        apb(1'h1, `ACJE_OFS_PSW, {27'h0, r.psw});
        apb(1'h1, `ACJE_OFS_CTRL, {29'h0, r.ctrl, 1'h1});
    endtask
    task automatic wait_done();
        do begin
            apb(1'h0, `ACJE_OFS_STAT, 32'h0);
        end while (rd[0] !== 1'h0);
    endtask
    task automatic check_row(input acje_row_t r);
        go(r);
        wait_done();
        if (r.e_stat[1])
            `ACJE_CHK("bad opcode", 1'h1, rd[1])
        else
            `ACJE_CHK("status", r.e_stat, {rd[9:7], rd[3:0]})
        apb(1'h0, `ACJE_OFS_ACC, 32'h0);
        `ACJE_CHK("acc", r.e_acc, rd[15:0])
        apb(1'h0, `ACJE_OFS_PSW, 32'h0);
        `ACJE_CHK("flags", r.e_psw, rd[4:0])
        apb(1'h0, `ACJE_OFS_SRC, 32'h0);
        `ACJE_CHK("source", r.src, rd[8:0])
    endtask
    task automatic jump_chk(input logic [15:0] ip, input logic [15:0] exp);
        apb(1'h1, `ACJE_OFS_IP, {16'h0, ip});
        go('{32'h00002321, 2'h0, 9'h0, 16'h0, 5'h0, 16'h0, 5'h0, 7'h0});
        wait_done();
        apb(1'h0, `ACJE_OFS_IP, 32'h0);
        `ACJE_CHK("jump target", exp, rd[15:0])
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        reset = 1'h1;
        apb_req = '0;
        pin_level = 8'h0F;
        err_count = 0;
        comparisons = 0;
        rows = '{
            '{32'h0000FF34, 2'h0, 9'h000, 16'h0001, 5'h00, 16'h0000, 5'h13, 7'h30},
            '{32'h00000038, 2'h0, 9'h0AA, 16'h00C3, 5'h01, 16'h006E, 5'h05, 7'h00},
            '{32'h00004035, 2'h0, 9'h07F, 16'h0000, 5'h01, 16'h0080, 5'h0E, 7'h10},
            '{32'h000037A5, 2'h1, 9'h020, 16'h0010, 5'h00, 16'h0030, 5'h00, 7'h20},
            '{32'h00008024, 2'h0, 9'h000, 16'h0080, 5'h01, 16'h0000, 5'h15, 7'h30},
            '{32'h00000F54, 2'h0, 9'h000, 16'h00F3, 5'h07, 16'h0003, 5'h07, 7'h30},
            '{32'h00000058, 2'h0, 9'h055, 16'h00AA, 5'h01, 16'h0000, 5'h11, 7'h00},
            '{32'h00002082, 2'h0, 9'h000, 16'h0012, 5'h01, 16'h0012, 5'h00, 7'h60},
            '{32'h00002082, 2'h0, 9'h100, 16'h0012, 5'h01, 16'h0012, 5'h01, 7'h60},
            '{32'h000020B0, 2'h0, 9'h100, 16'h0012, 5'h1F, 16'h0012, 5'h1E, 7'h60},
            '{32'h00008035, 2'h2, 9'h000, 16'h0001, 5'h00, 16'h0010, 5'h02, 7'h14},
            '{32'h00095EA5, 2'h0, 9'h00F, 16'h3C00, 5'h00, 16'h0C00, 5'h00, 7'h40},
            '{32'h00000B5E, 2'h1, 9'h0F0, 16'h3C55, 5'h01, 16'h3055, 5'h01, 7'h50},
            '{32'h00000038, 2'h1, 9'h000, 16'h0042, 5'h04, 16'h0042, 5'h04, 7'h02},
            '{32'h000038A5, 2'h0, 9'h000, 16'h0042, 5'h04, 16'h0042, 5'h04, 7'h02},
            '{32'h000038A5, 2'h1, 9'h001, 16'h00FF, 5'h00, 16'h0000, 5'h13, 7'h00}
        };
        repeat (2) @(posedge ref_clk);
        reset <= 1'h0;
        // Reset state of registers and latch
        for (int a = 0; a < 28; a += 4) begin
            apb(1'h0, 8'(a), 32'h0);
            `ACJE_CHK("reset reg", 32'h0, rd)
        end
        apb(1'h0, `ACJE_OFS_PORT, 32'h0);
        `ACJE_CHK("reset port", 32'h00000FFF, rd)
        $display("Test reset done");
        // Table of ordinary operations
        foreach (rows[i]) begin
            check_row(rows[i]);
        end
        $display("Test table done");
        // Unmapped and unaligned accesses
        apb(1'h0, 8'h20, 32'h0);
        `ACJE_CHK("unmapped err", 1'h1, er)
        `ACJE_CHK("unmapped data", 32'h0, rd)
        apb(1'h1, 8'h06, 32'h5);
        `ACJE_CHK("unaligned err", 1'h1, er)
        $display("Test refusal done");
        // AND of accumulator into port latch, write refused while busy
        apb(1'h1, `ACJE_OFS_PORT, 32'hF0);
        go('{32'h00009052, 2'h2, 9'h0, 16'h003C, 5'h07, 16'h0, 5'h0, 7'h0});
        apb(1'h1, `ACJE_OFS_ACC, 32'h1234);
        `ACJE_CHK("busy write err", 1'h1, er)
        wait_done();
        `ACJE_CHK("extra states", 2'h2, rd[3:2])
        `ACJE_CHK("port latch", 8'h30, port_out)
        apb(1'h0, `ACJE_OFS_ACC, 32'h0);
        `ACJE_CHK("acc kept", 32'h0000003C, rd)
        apb(1'h0, `ACJE_OFS_PSW, 32'h0);
        `ACJE_CHK("port flags", 5'h07, rd[4:0])
        $display("Test port done");
        // Page jump inside and across a page edge
        jump_chk(16'h0345, 16'h0123);
        jump_chk(16'h07FE, 16'h0923);
        $display("Test jump done");
        // Reset while a port instruction is still running
        go('{32'h00009052, 2'h2, 9'h0, 16'h0055, 5'h03, 16'h0, 5'h0, 7'h0});
        reset <= 1'h1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'h0;
        apb(1'h0, `ACJE_OFS_STAT, 32'h0);
        `ACJE_CHK("mid reset stat", 32'h0, rd)
        apb(1'h0, `ACJE_OFS_PORT, 32'h0);
        `ACJE_CHK("mid reset port", 32'h00000FFF, rd)
        apb(1'h0, `ACJE_OFS_PSW, 32'h0);
        `ACJE_CHK("mid reset flags", 32'h0, rd)
        $display("Test mid reset done");
        end_sim();
    end
endmodule
`default_nettype wire
